// ### test/gos_output_select_props.sv
// Checker of the output-select block: pin drivers after control writes, handshake, status reads.
// Assumes it is bound to gos_output_select; control register at byte address 3fc98.
module gos_output_select_props (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Bus
  input wire logic [gos_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [gos_pkg::DATA_W-1:0] avs_writedata_in,
  input wire logic [gos_pkg::BE_W-1:0] avs_byteenable_in,
  input wire logic [gos_pkg::DATA_W-1:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  // Pins and chip levels
  input wire logic tri_or_output_pin_out,
  input wire logic tri_or_output_pin_oe_n_out,
  input wire logic column_six_or_output_pin_out,
  input wire logic column_six_or_output_pin_oe_n_out,
  input wire logic column_five_or_output_pin_out,
  input wire logic column_five_or_output_pin_oe_n_out,
  input wire logic keypad_column_five_out,
  input wire logic general_output_six_in,
  input wire logic shutdown_in
);
  import gos_pkg::*;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  // Accepted control write and accepted read
  logic wr_ok;
  logic rd_ok;
  assign wr_ok = avs_write_in && !avs_waitrequest_out && avs_address_in == 18'h3_fc98 && avs_byteenable_in[0];
  assign rd_ok = avs_read_in && !avs_waitrequest_out;
  property p_tri_oe;
    logic [7:0] v;
    (wr_ok, v = avs_writedata_in[7:0]) |-> ##2 tri_or_output_pin_oe_n_out == !v[7];
  endproperty
  a_tri_oe: assert property (p_tri_oe) else $error("tri pin enable wrong");
  property p_tri_val;
    logic [7:0] v;
    (wr_ok, v = avs_writedata_in[7:0]) |-> ##2 tri_or_output_pin_oe_n_out || tri_or_output_pin_out == v[2];
  endproperty
  a_tri_val: assert property (p_tri_val) else $error("tri pin level wrong");
  property p_keypad_column_five_oe;
    logic [7:0] v;
    (wr_ok, v = avs_writedata_in[7:0]) |-> ##2 column_five_or_output_pin_oe_n_out == !v[5];
  endproperty
  a_keypad_column_five_oe: assert property (p_keypad_column_five_oe) else $error("column five enable wrong");
  property p_keypad_column_six_oe;
    logic [7:0] v;
    (wr_ok, v = avs_writedata_in[7:0]) |-> ##2 column_six_or_output_pin_oe_n_out == !(v[6] || (v[5] && v[4]));
  endproperty
  a_keypad_column_six_oe: assert property (p_keypad_column_six_oe) else $error("column six enable wrong");
  property p_osc;
    (wr_ok && avs_writedata_in[5] && avs_writedata_in[4]) |-> ##2 column_six_or_output_pin_out == !$past(shutdown_in);
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator enable wrong");
  property p_keypad_column_five_val;
    $past(resetn_in) && !column_five_or_output_pin_oe_n_out |->
      column_five_or_output_pin_out == $past(general_output_six_in);
  endproperty
  a_keypad_column_five_val: assert property (p_keypad_column_five_val) else $error("output six level wrong");
  property p_key5;
    !column_five_or_output_pin_oe_n_out && !$past(column_five_or_output_pin_oe_n_out) |-> keypad_column_five_out;
  endproperty
  a_key5: assert property (p_key5) else $error("column five level while output");
  property p_wait;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out;
  endproperty
  a_wait: assert property (p_wait) else $error("handshake timing wrong");
  property p_rsv;
    rd_ok && avs_address_in inside {18'h3_fca0, 18'h3_fca4} |-> avs_readdata_out[31:1] == 31'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved status bits not zero");
  // Unused bits of the first status byte read as zero
  property p_rsv0;
    rd_ok && avs_address_in == 18'h3_fc9c |-> avs_readdata_out[31:7] == 25'h0 && avs_readdata_out[2:1] == 2'h0;
  endproperty
  a_rsv0: assert property (p_rsv0) else $error("reserved level bits not zero");
endmodule : gos_output_select_props

bind gos_output_select gos_output_select_props i_gos_output_select_props (
  .clk_in, .resetn_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
  .avs_readdata_out, .avs_waitrequest_out, .tri_or_output_pin_out, .tri_or_output_pin_oe_n_out,
  .column_six_or_output_pin_out, .column_six_or_output_pin_oe_n_out, .column_five_or_output_pin_out,
  .column_five_or_output_pin_oe_n_out, .keypad_column_five_out, .general_output_six_in, .shutdown_in
);

// ### test/gos_pin_model.sv
// Outside pins of the block: tri-level comparators and keypad columns.
// Assumes the bench sets levels just after a rising edge; a driven column shows the block's level.
module gos_pin_model (
  // Pin states from the bench: 0 open, 1 low, 2 high
  input wire logic [1:0] tri_zero_cmd_in,
  input wire logic [1:0] tri_one_cmd_in,
  // Key levels, high when no key is down
  input wire logic key_five_in,
  input wire logic key_six_in,
  // Block drivers
  input wire logic column_six_or_output_pin_out,
  input wire logic column_six_or_output_pin_oe_n_out,
  input wire logic column_five_or_output_pin_out,
  input wire logic column_five_or_output_pin_oe_n_out,
  // Levels seen by the block
  output logic tri_zero_low_out,
  output logic tri_zero_high_out,
  output logic tri_one_low_out,
  output logic tri_one_high_out,
  output logic column_six_level_out,
  output logic column_five_level_out
);
  // Comparators: an open pin trips neither threshold
  assign tri_zero_low_out = tri_zero_cmd_in == 2'h1;
  assign tri_zero_high_out = tri_zero_cmd_in == 2'h2;
  assign tri_one_low_out = tri_one_cmd_in == 2'h1;
  assign tri_one_high_out = tri_one_cmd_in == 2'h2;
  // Column wires: the block wins while it drives
  assign column_six_level_out = column_six_or_output_pin_oe_n_out ? key_six_in : column_six_or_output_pin_out;
  assign column_five_level_out = column_five_or_output_pin_oe_n_out ? key_five_in : column_five_or_output_pin_out;
endmodule : gos_pin_model

// ### test/testbench.sv
// Self-checking bench of gos_output_select with the outside pin model.
// Assumes gos_pkg and the design compile first; one 50 MHz clock.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import gos_pkg::*;
  localparam logic [ADDR_W-1:0] CTRL_A = 18'h3_fc98;
  localparam logic [ADDR_W-1:0] ST0_A = 18'h3_fc9c;
  localparam logic [ADDR_W-1:0] ST1_A = 18'h3_fca0;
  localparam logic [ADDR_W-1:0] ST2_A = 18'h3_fca4;
  // Rows: control byte, expected enables of tri, keypad_column_six, keypad_column_five, tri level, keypad_column_six level
  localparam logic [12:0] ROWS [8] = '{
    {8'h04, 3'h7, 1'h1, 1'h0}, {8'h80, 3'h3, 1'h0, 1'h0}, {8'h84, 3'h3, 1'h1, 1'h0}, {8'h40, 3'h5, 1'h0, 1'h0},
    {8'h30, 3'h4, 1'h0, 1'h1}, {8'h10, 3'h7, 1'h0, 1'h0}, {8'h70, 3'h4, 1'h0, 1'h1}, {8'h20, 3'h6, 1'h0, 1'h0}};
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [ADDR_W-1:0] avs_address_in = '0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [DATA_W-1:0] avs_writedata_in = '0;
  logic [BE_W-1:0] avs_byteenable_in = 4'hf;
  logic [DATA_W-1:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic tri_zero_low_in, tri_zero_high_in, tri_one_low_in, tri_one_high_in;
  logic tri_or_output_pin_out, tri_or_output_pin_oe_n_out;
  logic column_six_or_output_pin_in, column_six_or_output_pin_out, column_six_or_output_pin_oe_n_out;
  logic column_five_or_output_pin_in, column_five_or_output_pin_out, column_five_or_output_pin_oe_n_out;
  logic [2:0] ext_int = 3'h0;
  logic general_output_seven_in = 1'b0;
  logic general_output_six_in = 1'b0;
  logic shutdown_in = 1'b0;
  logic keypad_column_six_out, keypad_column_five_out;
  logic [1:0] tri_zero_cmd = 2'h0;
  logic [1:0] tri_one_cmd = 2'h0;
  logic key_five = 1'b1;
  logic key_six = 1'b1;
  logic [DATA_W-1:0] q;
  int bad_count = 0;
  int comparisons = 0;

  // Clock
  always #10 clk_in = ~clk_in;

  gos_output_select i_gos_output_select (
    .clk_in, .resetn_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
    .avs_readdata_out, .avs_waitrequest_out, .tri_zero_low_in, .tri_zero_high_in, .tri_or_output_pin_out,
    .tri_or_output_pin_oe_n_out, .tri_one_low_in, .tri_one_high_in, .column_six_or_output_pin_in,
    .column_six_or_output_pin_out, .column_six_or_output_pin_oe_n_out, .column_five_or_output_pin_in,
    .column_five_or_output_pin_out, .column_five_or_output_pin_oe_n_out, .ext_interrupt_line_zero_in(ext_int[0]),
    .ext_interrupt_line_one_in(ext_int[1]), .ext_interrupt_line_two_in(ext_int[2]), .general_output_seven_in,
    .general_output_six_in, .shutdown_in, .keypad_column_six_out, .keypad_column_five_out
  );

  gos_pin_model i_gos_pin_model (
    .tri_zero_cmd_in(tri_zero_cmd), .tri_one_cmd_in(tri_one_cmd), .key_five_in(key_five), .key_six_in(key_six),
    .column_six_or_output_pin_out, .column_six_or_output_pin_oe_n_out, .column_five_or_output_pin_out,
    .column_five_or_output_pin_oe_n_out, .tri_zero_low_out(tri_zero_low_in), .tri_zero_high_out(tri_zero_high_in),
    .tri_one_low_out(tri_one_low_in), .tri_one_high_out(tri_one_high_in),
    .column_six_level_out(column_six_or_output_pin_in), .column_five_level_out(column_five_or_output_pin_in)
  );

  // Verdict and end of run
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc

  // One bus transfer; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_write_in <= w;
    avs_read_in <= !w;
    avs_writedata_in <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    if (avs_waitrequest_out !== 1'b0) begin
      bad_count++;
      complete_run();
    end
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask : bus

  function automatic logic [1:0] code(input int c);
    return c == 0 ? TRI_OPEN : (c == 1 ? TRI_LOW : TRI_HIGH);
  endfunction : code

  // Main sequence
  initial begin
    int i;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    bus(1'b0, CTRL_A, 8'h00);
    check(q, 32'h0000_0004);
    for (i = 0; i < 8; i++) begin
      bus(1'b1, CTRL_A, ROWS[i][12:5]);
      cyc(2);
      check({tri_or_output_pin_oe_n_out, column_six_or_output_pin_oe_n_out, column_five_or_output_pin_oe_n_out},
        ROWS[i][4:2]);
      check(tri_or_output_pin_out, ROWS[i][1]);
      check(column_six_or_output_pin_out, ROWS[i][0]);
      bus(1'b0, CTRL_A, 8'h00);
      check(q, {24'h00_0000, ROWS[i][12:5]});
      $display("test row %0d done", i);
    end
    bus(1'b1, CTRL_A, 8'h60);
    general_output_seven_in <= 1'b1;
    general_output_six_in <= 1'b1;
    cyc(3);
    check({column_six_or_output_pin_out, column_five_or_output_pin_out, keypad_column_six_out,
      keypad_column_five_out}, 4'hf);
    bus(1'b1, CTRL_A, 8'h30);
    shutdown_in <= 1'b1;
    cyc(3);
    check(column_six_or_output_pin_out, 1'b0);
    $display("test chip levels done");
    bus(1'b1, CTRL_A, 8'h00);
    key_five <= 1'b0;
    cyc(5);
    check({keypad_column_six_out, keypad_column_five_out}, 2'h2);
    $display("test keypad done");
    for (i = 0; i < 3; i++) begin
      tri_zero_cmd <= i[1:0];
      tri_one_cmd <= 2'h2 - i[1:0];
      ext_int <= {i[0], !i[0], i[0]};
      cyc(5);
      bus(1'b0, ST0_A, 8'h00);
      check(q, {25'h0, code(2 - i), code(i), 2'h0, ext_int[0]});
      bus(1'b1, ST1_A, 8'hff);
      bus(1'b0, ST1_A, 8'h00);
      check(q, {31'h0, ext_int[1]});
      bus(1'b0, ST2_A, 8'h00);
      check(q, {31'h0, ext_int[2]});
      $display("test status %0d done", i);
    end
    bus(1'b0, 18'h3_fcac, 8'h00);
    check(q, 32'h0);
    bus(1'b1, 18'h3_fc99, 8'hff);
    // Control write without its byte lane is ignored
    avs_byteenable_in <= 4'he;
    bus(1'b1, CTRL_A, 8'hff);
    avs_byteenable_in <= 4'hf;
    bus(1'b0, CTRL_A, 8'h00);
    check(q, 32'h0);
    bus(1'b1, CTRL_A, 8'he4);
    resetn_in <= 1'b0;
    cyc(2);
    check({tri_or_output_pin_oe_n_out, column_six_or_output_pin_oe_n_out, column_five_or_output_pin_oe_n_out},
      3'h7);
    resetn_in <= 1'b1;
    bus(1'b0, CTRL_A, 8'h00);
    check(q, 32'h0000_0004);
    $display("test reset done");
    complete_run();
  end
endmodule : testbench

// ### verilog/gos_output_select.sv
// Output-select control register, multifunction pin drivers and pin-level status registers.
// Assumes an Avalon-MM master that holds its request until waitrequest is seen low,
// and outside comparators that report a tri-level pin as below-low and above-high lines.
//
// Local design decision: the Avalon-MM register port.
import gos_pkg::*;

// Functional notes
// [R1] Control bits 7, 6, 5 turn tri pin and columns six, five into outputs.
// [R2] Output ten is driven on its pin only while control bit 7 is one.
// [R3] Output ten pin is low when control bit 2 is zero, high when one.
// [R4] Low control bits are stored even while their pin is an input.
// [R5] Bit 4 drives active-high oscillator enable, shutdown state, onto column six pin.
// [R6] Oscillator enable selection applies only while control bit 5 is set.
// [R7] First status: tri one in bits 6-5, tri zero in 4-3, interrupt zero bit 0.
// [R8] Second status bit 0 reads the level of interrupt line one.
// [R9] Third status bit 0 reads the level of interrupt line two.
// [R10] Reserved status bits read as zero.
// [R11] Tri-level code: open, low, high; fourth code unused.
// [R12] Pin levels are synchronised to the clock before they reach status.
module gos_output_select (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Avalon-MM slave
  input wire logic [gos_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [gos_pkg::DATA_W-1:0] avs_writedata_in,
  input wire logic [gos_pkg::BE_W-1:0] avs_byteenable_in,
  output logic [gos_pkg::DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Tri-level pin zero, shared with general output ten
  input wire logic tri_zero_low_in,
  input wire logic tri_zero_high_in,
  output logic tri_or_output_pin_out,
  output logic tri_or_output_pin_oe_n_out,
  // Tri-level pin one
  input wire logic tri_one_low_in,
  input wire logic tri_one_high_in,
  // Column six pin, shared with output seven and oscillator enable
  input wire logic column_six_or_output_pin_in,
  output logic column_six_or_output_pin_out,
  output logic column_six_or_output_pin_oe_n_out,
  // Column five pin, shared with output six
  input wire logic column_five_or_output_pin_in,
  output logic column_five_or_output_pin_out,
  output logic column_five_or_output_pin_oe_n_out,
  // External interrupt lines
  input wire logic ext_interrupt_line_zero_in,
  input wire logic ext_interrupt_line_one_in,
  input wire logic ext_interrupt_line_two_in,
  // Values from the rest of the chip, same clock
  input wire logic general_output_seven_in,
  input wire logic general_output_six_in,
  input wire logic shutdown_in,
  // Column levels towards the keypad scanner
  output logic keypad_column_six_out,
  output logic keypad_column_five_out
);
  import gos_pkg::*;

  // Synchronised pin levels
  logic [SYNC_W-1:0] pin_async;
  logic [SYNC_W-1:0] pin_sync;
  logic [1:0] tri_zero_code;
  logic [1:0] tri_one_code;

  // Bus state
  gos_bus_e bus_state_reg;
  gos_bus_e bus_state_next;
  logic [DATA_W-1:0] readdata_reg;
  logic [DATA_W-1:0] readdata_next;
  logic waitrequest_reg;
  logic waitrequest_next;

  // Control register
  logic [REG_W-1:0] ctrl_reg;
  logic [REG_W-1:0] ctrl_next;

  // Status registers
  logic [REG_W-1:0] stat0_reg;
  logic [REG_W-1:0] stat0_next;
  logic [REG_W-1:0] stat1_reg;
  logic [REG_W-1:0] stat1_next;
  logic [REG_W-1:0] stat2_reg;
  logic [REG_W-1:0] stat2_next;

  // Pin drivers
  logic tri_pin_reg;
  logic tri_pin_next;
  logic tri_oe_n_reg;
  logic tri_oe_n_next;
  logic keypad_column_six_pin_reg;
  logic keypad_column_six_pin_next;
  logic keypad_column_six_oe_n_reg;
  logic keypad_column_six_oe_n_next;
  logic keypad_column_five_pin_reg;
  logic keypad_column_five_pin_next;
  logic keypad_column_five_oe_n_reg;
  logic keypad_column_five_oe_n_next;
  logic keypad_column_six_level_reg;
  logic keypad_column_six_level_next;
  logic keypad_column_five_level_reg;
  logic keypad_column_five_level_next;

  // Bus decode helpers
  logic req;
  logic accept;
  logic hit_ctrl;
  logic hit_stat0;
  logic hit_stat1;
  logic hit_stat2;
  logic osc_enable;

  // Gather every outside level into one bundle
  assign pin_async[SYNC_TRI0_LOW] = tri_zero_low_in;
  assign pin_async[SYNC_TRI0_HIGH] = tri_zero_high_in;
  assign pin_async[SYNC_TRI1_LOW] = tri_one_low_in;
  assign pin_async[SYNC_TRI1_HIGH] = tri_one_high_in;
  assign pin_async[SYNC_KEYPAD_COLUMN_FIVE] = column_five_or_output_pin_in;
  assign pin_async[SYNC_KEYPAD_COLUMN_SIX] = column_six_or_output_pin_in;
  assign pin_async[SYNC_INT0] = ext_interrupt_line_zero_in;
  assign pin_async[SYNC_INT1] = ext_interrupt_line_one_in;
  assign pin_async[SYNC_INT2] = ext_interrupt_line_two_in;

  // Bring levels into the clock domain
  gos_sync2 #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .d_in(pin_async),
    .q_out(pin_sync) // [R12]
  );

  // Turn sense lines into tri-level codes
  gos_tri_decode u_tri (
    .tri_zero_low_in(pin_sync[SYNC_TRI0_LOW]),
    .tri_zero_high_in(pin_sync[SYNC_TRI0_HIGH]),
    .tri_one_low_in(pin_sync[SYNC_TRI1_LOW]),
    .tri_one_high_in(pin_sync[SYNC_TRI1_HIGH]),
    .tri_zero_code_out(tri_zero_code),
    .tri_one_code_out(tri_one_code)
  );

  // Address decode of the current request
  assign req = avs_read_in || avs_write_in;
  assign hit_ctrl = gos_hit(avs_address_in, IDX_OUTPUT_SELECT_CONTROL_ONE);
  assign hit_stat0 = gos_hit(avs_address_in, IDX_TRI_LEVEL_AND_INT0_LEVELS);
  assign hit_stat1 = gos_hit(avs_address_in, IDX_EXT_INT_ONE_LEVEL);
  assign hit_stat2 = gos_hit(avs_address_in, IDX_EXT_INT_TWO_LEVEL);
  // Request completes at the edge where waitrequest is low
  assign accept = req && (bus_state_reg == GOS_BUS_ACK);

  // Handshake: one wait cycle, then one cycle with waitrequest low
  always_comb begin
    bus_state_next = bus_state_reg;
    waitrequest_next = 1'b1;
    readdata_next = readdata_reg;
    case (bus_state_reg)
      GOS_BUS_IDLE: begin
        if (req) begin
          bus_state_next = GOS_BUS_ACK;
          waitrequest_next = 1'b0;
          readdata_next = READ_ZERO;
          if (avs_read_in) begin
            if (hit_ctrl) begin
              readdata_next[REG_W-1:0] = ctrl_reg;
            end else if (hit_stat0) begin
              readdata_next[REG_W-1:0] = stat0_reg;
            end else if (hit_stat1) begin
              readdata_next[REG_W-1:0] = stat1_reg;
            end else if (hit_stat2) begin
              readdata_next[REG_W-1:0] = stat2_reg;
            end
          end
        end
      end
      GOS_BUS_ACK: begin
        bus_state_next = GOS_BUS_IDLE;
        waitrequest_next = 1'b1;
      end
      default: begin
        bus_state_next = GOS_BUS_IDLE;
        waitrequest_next = 1'b1;
      end
    endcase
  end

  // Bus registers
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bus_state_reg <= GOS_BUS_IDLE;
      waitrequest_reg <= 1'b1;
      readdata_reg <= READ_ZERO;
    end else begin
      bus_state_reg <= bus_state_next;
      waitrequest_reg <= waitrequest_next;
      readdata_reg <= readdata_next;
    end
  end

  // Control write: whole byte stored whatever the pin roles are
  always_comb begin
    ctrl_next = ctrl_reg;
    if (accept && avs_write_in && hit_ctrl && avs_byteenable_in[0]) begin
      ctrl_next = avs_writedata_in[REG_W-1:0]; // [R4]
    end
  end

  // Control register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_reg <= CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Status bytes from synchronised levels; unused bits stay zero
  always_comb begin
    stat0_next = BYTE_ZERO; // [R10]
    stat0_next[STAT_TRI1_LSB +: 2] = tri_one_code; // [R7]
    stat0_next[STAT_TRI0_LSB +: 2] = tri_zero_code; // [R7]
    stat0_next[STAT_LEVEL_BIT] = pin_sync[SYNC_INT0]; // [R7]
    stat1_next = BYTE_ZERO; // [R10]
    stat1_next[STAT_LEVEL_BIT] = pin_sync[SYNC_INT1]; // [R8]
    stat2_next = BYTE_ZERO; // [R10]
    stat2_next[STAT_LEVEL_BIT] = pin_sync[SYNC_INT2]; // [R9]
  end

  // Status registers
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stat0_reg <= BYTE_ZERO;
      stat1_reg <= BYTE_ZERO;
      stat2_reg <= BYTE_ZERO;
    end else begin
      stat0_reg <= stat0_next;
      stat1_reg <= stat1_next;
      stat2_reg <= stat2_next;
    end
  end

  // Oscillator runs while the chip is not shut down
  assign osc_enable = !shutdown_in; // [R5]

  // Pin roles from the control bits
  always_comb begin
    // Tri pin: output ten only when selected
    tri_oe_n_next = !ctrl_reg[CTRL_TRI_OUT_SEL_BIT]; // [R1] [R2]
    tri_pin_next = ctrl_reg[CTRL_GENERAL_OUTPUT_TEN_BIT]; // [R3]
    // Column six: oscillator enable, else output seven, else input
    keypad_column_six_oe_n_next = 1'b1;
    keypad_column_six_pin_next = 1'b0;
    if (ctrl_reg[CTRL_KEYPAD_COLUMN_FIVE_OUT_SEL_BIT] && ctrl_reg[CTRL_OSC_SEL_BIT]) begin
      keypad_column_six_oe_n_next = 1'b0; // [R5] [R6]
      keypad_column_six_pin_next = osc_enable; // [R5]
    end else if (ctrl_reg[CTRL_KEYPAD_COLUMN_SIX_OUT_SEL_BIT]) begin
      keypad_column_six_oe_n_next = 1'b0; // [R1]
      keypad_column_six_pin_next = general_output_seven_in;
    end
    // Column five: output six or input
    keypad_column_five_oe_n_next = !ctrl_reg[CTRL_KEYPAD_COLUMN_FIVE_OUT_SEL_BIT]; // [R1]
    keypad_column_five_pin_next = general_output_six_in;
    // Column levels read as idle high while the pin is an output
    keypad_column_six_level_next = keypad_column_six_oe_n_next ? pin_sync[SYNC_KEYPAD_COLUMN_SIX] : 1'b1;
    keypad_column_five_level_next = keypad_column_five_oe_n_next ? pin_sync[SYNC_KEYPAD_COLUMN_FIVE] : 1'b1;
  end

  // Pin driver registers; all pins are inputs during reset
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tri_pin_reg <= 1'b0;
      tri_oe_n_reg <= 1'b1;
      keypad_column_six_pin_reg <= 1'b0;
      keypad_column_six_oe_n_reg <= 1'b1;
      keypad_column_five_pin_reg <= 1'b0;
      keypad_column_five_oe_n_reg <= 1'b1;
      keypad_column_six_level_reg <= 1'b1;
      keypad_column_five_level_reg <= 1'b1;
    end else begin
      tri_pin_reg <= tri_pin_next;
      tri_oe_n_reg <= tri_oe_n_next;
      keypad_column_six_pin_reg <= keypad_column_six_pin_next;
      keypad_column_six_oe_n_reg <= keypad_column_six_oe_n_next;
      keypad_column_five_pin_reg <= keypad_column_five_pin_next;
      keypad_column_five_oe_n_reg <= keypad_column_five_oe_n_next;
      keypad_column_six_level_reg <= keypad_column_six_level_next;
      keypad_column_five_level_reg <= keypad_column_five_level_next;
    end
  end

  // Outputs straight from flip-flops
  assign avs_readdata_out = readdata_reg;
  assign avs_waitrequest_out = waitrequest_reg;
  assign tri_or_output_pin_out = tri_pin_reg;
  assign tri_or_output_pin_oe_n_out = tri_oe_n_reg;
  assign column_six_or_output_pin_out = keypad_column_six_pin_reg;
  assign column_six_or_output_pin_oe_n_out = keypad_column_six_oe_n_reg;
  assign column_five_or_output_pin_out = keypad_column_five_pin_reg;
  assign column_five_or_output_pin_oe_n_out = keypad_column_five_oe_n_reg;
  assign keypad_column_six_out = keypad_column_six_level_reg;
  assign keypad_column_five_out = keypad_column_five_level_reg;

endmodule : gos_output_select

// ### verilog/gos_pkg.sv
// Shared constants for the output-select and pin-status block.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one aligned word per register.
package gos_pkg;

  // Bus geometry
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int REG_W = 8;
  localparam int IDX_W = 16;

  // Register indices as printed; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_OUTPUT_SELECT_CONTROL_ONE = 16'hff26;
  localparam logic [IDX_W-1:0] IDX_TRI_LEVEL_AND_INT0_LEVELS = 16'hff27;
  localparam logic [IDX_W-1:0] IDX_EXT_INT_ONE_LEVEL = 16'hff28;
  localparam logic [IDX_W-1:0] IDX_EXT_INT_TWO_LEVEL = 16'hff29;

  // Control register reset value and field positions
  localparam logic [REG_W-1:0] CTRL_RESET = 8'h04;
  localparam int CTRL_TRI_OUT_SEL_BIT = 7;
  localparam int CTRL_KEYPAD_COLUMN_SIX_OUT_SEL_BIT = 6;
  localparam int CTRL_KEYPAD_COLUMN_FIVE_OUT_SEL_BIT = 5;
  localparam int CTRL_OSC_SEL_BIT = 4;
  localparam int CTRL_GENERAL_OUTPUT_TEN_BIT = 2;

  // Status register field positions
  localparam int STAT_TRI1_LSB = 5;
  localparam int STAT_TRI0_LSB = 3;
  localparam int STAT_LEVEL_BIT = 0;

  // Tri-level pin codes
  localparam logic [1:0] TRI_OPEN = 2'b00;
  localparam logic [1:0] TRI_LOW = 2'b01;
  localparam logic [1:0] TRI_HIGH = 2'b10;

  // Synchroniser sizing: four tri sense lines, two columns, three interrupt lines
  localparam int SYNC_W = 9;
  localparam int SYNC_TRI0_LOW = 0;
  localparam int SYNC_TRI0_HIGH = 1;
  localparam int SYNC_TRI1_LOW = 2;
  localparam int SYNC_TRI1_HIGH = 3;
  localparam int SYNC_KEYPAD_COLUMN_FIVE = 4;
  localparam int SYNC_KEYPAD_COLUMN_SIX = 5;
  localparam int SYNC_INT0 = 6;
  localparam int SYNC_INT1 = 7;
  localparam int SYNC_INT2 = 8;

  // Reset values of the bus answer
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
  localparam logic [REG_W-1:0] BYTE_ZERO = 8'h00;

  // Bus handshake states
  typedef enum logic [0:0] {
    GOS_BUS_IDLE = 1'b0,
    GOS_BUS_ACK = 1'b1
  } gos_bus_e;

  // True when a byte address selects the given register index
  function automatic logic gos_hit(input logic [ADDR_W-1:0] addr, input logic [IDX_W-1:0] idx);
    gos_hit = (addr[ADDR_W-1:2] == idx) && (addr[1:0] == 2'b00);
  endfunction : gos_hit

endpackage : gos_pkg

// ### verilog/gos_sync2.sv
// Two-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes each bit is an independent level; no bundle coherency is promised.
module gos_sync2 #(
  parameter int WIDTH = gos_pkg::SYNC_W
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Levels
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  import gos_pkg::*;

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // First stage feeds only the second stage
  always_comb begin
    meta_next = d_in;
    sync_next = meta_reg;
  end

  // Stage registers
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign q_out = sync_reg;

endmodule : gos_sync2

// ### verilog/gos_tri_decode.sv
// Decoder from two threshold sense lines to a tri-level pin code.
// Assumes sense lines are already synchronised to the system clock.
module gos_tri_decode (
  // Sense lines of pin zero
  input wire logic tri_zero_low_in,
  input wire logic tri_zero_high_in,
  // Sense lines of pin one
  input wire logic tri_one_low_in,
  input wire logic tri_one_high_in,
  // Codes
  output logic [1:0] tri_zero_code_out,
  output logic [1:0] tri_one_code_out
);
  import gos_pkg::*;

  // Map one pin; both lines active cannot happen and reads as open
  function automatic logic [1:0] tri_code(input logic low, input logic high);
    if (low && !high) begin
      tri_code = TRI_LOW;
    end else if (high && !low) begin
      tri_code = TRI_HIGH;
    end else begin
      tri_code = TRI_OPEN;
    end
  endfunction : tri_code

  // Both pins decoded the same way
  assign tri_zero_code_out = tri_code(tri_zero_low_in, tri_zero_high_in); // [R11]
  assign tri_one_code_out = tri_code(tri_one_low_in, tri_one_high_in); // [R11]

endmodule : gos_tri_decode
